// ### common/pff_pkg.sv
package pff_pkg;

  // Register map, byte addresses on the AXI4-Lite slave
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] REG_SPAN_LO = 8'h04;
  localparam logic [AXI_AW-1:0] REG_SPAN_HI = 8'h08;
  localparam logic [AXI_AW-1:0] REG_DISP_LO = 8'h0c;
  localparam logic [AXI_AW-1:0] REG_DISP_HI = 8'h10;
  localparam logic [AXI_AW-1:0] REG_PPL = 8'h14;
  localparam logic [AXI_AW-1:0] REG_SMOOTH = 8'h18;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h1c;
  localparam logic [AXI_AW-1:0] REG_MASK = 8'h20;
  localparam logic [AXI_AW-1:0] REG_RATE = 8'h24;
  localparam logic [AXI_AW-1:0] REG_VALUE = 8'h28;

  // Control register field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_COND_LSB = 1;
  localparam int CTRL_LIMIT_LSB = 3;
  localparam int CTRL_UNIT_LSB = 5;
  localparam int CTRL_DP_LSB = 7;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SPAN_LO_RST = 32'h0000_0000;
  localparam logic [31:0] SPAN_HI_RST = 32'h0000_270f;
  localparam logic [31:0] DISP_LO_RST = 32'h0000_0000;
  localparam logic [31:0] DISP_HI_RST = 32'h0000_270f;
  localparam logic [31:0] PPL_RST = 32'h0000_0001;
  localparam logic [31:0] SMOOTH_RST = 32'h0000_0000;
  localparam logic [2:0] STATUS_RST = 3'h0;

  // Status and mask bit positions
  localparam int ST_OVER = 0;
  localparam int ST_SPAN = 1;
  localparam int ST_DONE = 2;
  localparam int ST_W = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int GATE_TIME_MS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int unsigned PFF_GATE_CYCLES = GATE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RATE_W = 16;
  localparam logic [RATE_W-1:0] MAX_RATE_HZ = 16'h2710;
  localparam logic [RATE_W-1:0] RATE_SAT = 16'hffff;
  localparam int SEC_PER_MIN = 60;
  localparam int SEC_PER_HOUR = 3600;
  // Gate time expressed in smoothing units of 0.01 s
  localparam int SMOOTH_STEP = GATE_TIME_MS / 10;

  typedef enum logic [0:0] {
    PULSE_RATE_MODE = 1'b0,
    FLOW_MODE = 1'b1
  } pff_mode_type;

  typedef enum logic [1:0] {
    LOGIC_LEVEL_INPUT = 2'b00,
    NPN_CONTACT = 2'b01,
    PNP_CONTACT = 2'b10,
    COND_SPARE = 2'b11
  } pff_cond_type;

  typedef enum logic [1:0] {
    LIMIT_OFF = 2'b00,
    BOUND_WITH_ERROR = 2'b01,
    BOUND_WITH_CLAMP = 2'b10,
    LIMIT_SPARE = 2'b11
  } pff_limit_type;

  typedef enum logic [1:0] {
    PER_SECOND = 2'b00,
    PER_MINUTE = 2'b01,
    PER_HOUR = 2'b10,
    UNIT_SPARE = 2'b11
  } pff_unit_type;

  typedef struct packed {
    pff_mode_type mode;
    pff_cond_type input_conditioning_select;
    pff_limit_type limit;
    pff_unit_type unit;
    logic [1:0] dp;
    logic [13:0] span_low_hz;
    logic [13:0] span_high_hz;
    logic signed [15:0] display_value_low;
    logic signed [15:0] display_value_high;
    logic [9:0] pulses_per_litre;
    logic [7:0] smoothing_constant;
  } pff_cfg_type;

endpackage

// ### hdl/pff_smooth.sv
`timescale 1ns/1ns
module pff_smooth
  import pff_pkg::*;
#(
  parameter int W = RATE_W
)
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_valid,
  input wire logic [W-1:0] i_value,
  input wire logic [7:0] i_tau,
  output logic o_valid,
  output logic [W-1:0] o_value
);

  logic seeded;
  logic signed [31:0] diff;
  logic signed [31:0] step;

  // First-order low pass, one step per gate; tau in units of 0.01 s
  always_comb
  begin
    diff = $signed({{(32-W){1'b0}}, i_value}) - $signed({{(32-W){1'b0}}, o_value});
    step = (diff * SMOOTH_STEP) / (SMOOTH_STEP + $signed({24'h0, i_tau}));
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_value <= '0;
      seeded <= 1'b0;
    end
    else if (i_valid)
    begin
      seeded <= 1'b1;
      // Off bypasses the filter entirely, as does the first sample after reset
      if (i_tau == 8'h0 || !seeded)
        o_value <= i_value;
      else
        o_value <= W'(o_value + step[W-1:0]);
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      o_valid <= 1'b0;
    else
      o_valid <= i_valid;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  a_filter_bypass: assert property (i_valid && i_tau == 8'h0 |=> o_valid && o_value == $past(i_value))
    else $error("Smoothing off did not pass the sample straight through");
  a_filter_bounded: assert property (i_valid && seeded && i_tau != 8'h0 && i_value >= o_value
      |=> o_value <= $past(i_value) && o_value >= $past(o_value))
    else $error("Smoothed value left the range between old output and new sample");

endmodule // pff_smooth

// ### hdl/pff_flow_meter.sv
`timescale 1ns/1ns
// Contract
// - Pulse input offers logic level, NPN with pull-up, PNP with pull-down.
// - Frequency span maps linearly onto the display span.
// - Limit off: scaled values continue beyond the span until absolute limit.
// - Error bounding: error shown when rate leaves the frequency span.
// - Clamping: low or high display value shown outside the span.
// - Above 10 kHz the over-range error shows under any limit policy.
// - Flow mode shares input choices, decimal point and smoothing.
// - Smoothing is a low pass, off or 0.01 to 2.00 s; the 8-bit register also accepts up to 2.55 s.
module pff_flow_meter
  import pff_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = PFF_GATE_CYCLES
)
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_pulse,
  output logic o_pullup_en,
  output logic o_pulldown_en,
  output logic signed [31:0] o_display_value,
  output logic [1:0] o_dp,
  output logic o_err_over,
  output logic o_err_span,
  output logic o_irq,
  input wire logic [AXI_AW-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [AXI_AW-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready
);

  typedef enum logic [1:0] {
    PH_GATE = 2'b00,
    PH_FILT = 2'b01,
    PH_SCALE = 2'b10
  } pff_phase_type;

  pff_phase_type phase;
  pff_cfg_type cfg;
  logic [31:0] ctrl_reg, span_lo_reg, span_hi_reg, disp_lo_reg, disp_hi_reg, ppl_reg, smooth_reg;
  logic [ST_W-1:0] status, mask;
  logic [AXI_AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held, w_held, do_write;
  logic [31:0] gate_cnt;
  logic [RATE_W-1:0] pulse_cnt, raw_rate;
  logic pulse_q, cond_pulse, gate_end, filt_valid;
  logic [RATE_W-1:0] filt_rate;
  logic scale_step;
  logic signed [39:0] f, num, den, lin, flow, mult, ppl;
  logic below, above, over;
  logic signed [31:0] next_display;
  logic next_err_span;
  logic [ST_W-1:0] set_bits, clr_bits;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = data[8*b +: 8];
    return r;
  endfunction

  // Configuration view of the registers
  always_comb
  begin
    cfg.mode = pff_mode_type'(ctrl_reg[CTRL_MODE_BIT]);
    cfg.input_conditioning_select = pff_cond_type'(ctrl_reg[CTRL_COND_LSB +: 2]);
    cfg.limit = pff_limit_type'(ctrl_reg[CTRL_LIMIT_LSB +: 2]);
    cfg.unit = pff_unit_type'(ctrl_reg[CTRL_UNIT_LSB +: 2]);
    cfg.dp = ctrl_reg[CTRL_DP_LSB +: 2];
    cfg.span_low_hz = span_lo_reg[13:0];
    cfg.span_high_hz = span_hi_reg[13:0];
    cfg.display_value_low = disp_lo_reg[15:0];
    cfg.display_value_high = disp_hi_reg[15:0];
    cfg.pulses_per_litre = ppl_reg[9:0];
    cfg.smoothing_constant = smooth_reg[7:0];
  end

  // Input conditioning: the pad resistors follow the selection in both modes
  assign o_pullup_en = (cfg.input_conditioning_select == NPN_CONTACT);
  assign o_pulldown_en = (cfg.input_conditioning_select == PNP_CONTACT);
  // NPN contacts pull the line low when closed, so count the inverted level
  assign cond_pulse = (cfg.input_conditioning_select == NPN_CONTACT) ? ~i_pulse : i_pulse;

  // Gate counting; every rising edge counts up to RATE_SAT, a bouncing contact inflates the rate
  assign gate_end = (gate_cnt == GATE_CYCLES - 1);
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      // A level already high at reset is not an edge, so no false count follows reset
      pulse_q <= 1'b1;
      gate_cnt <= '0;
      pulse_cnt <= '0;
      raw_rate <= '0;
    end
    else
    begin
      pulse_q <= cond_pulse;
      gate_cnt <= gate_end ? '0 : gate_cnt + 32'h1;
      if (gate_end)
      begin
        raw_rate <= pulse_cnt;
        pulse_cnt <= (cond_pulse && !pulse_q) ? RATE_W'(1) : '0;
      end
      else if (cond_pulse && !pulse_q && pulse_cnt != RATE_SAT)
        pulse_cnt <= pulse_cnt + RATE_W'(1);
    end
  end

  pff_smooth #(.W(RATE_W)) u_smooth (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_valid(phase == PH_GATE && gate_end),
    .i_value(pulse_cnt),
    .i_tau(cfg.smoothing_constant),
    .o_valid(filt_valid),
    .o_value(filt_rate)
  );

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      phase <= PH_GATE;
    else
      case (phase)
        PH_GATE: if (gate_end) phase <= PH_FILT;
        PH_FILT: if (filt_valid) phase <= PH_SCALE;
        PH_SCALE: phase <= PH_GATE;
        default: phase <= PH_GATE;
      endcase
  end
  assign scale_step = (phase == PH_SCALE);

  // Scaling arithmetic; wide enough that no intermediate can overflow
  always_comb
  begin
    f = $signed({24'h0, filt_rate});
    num = (f - $signed({26'h0, cfg.span_low_hz}))
      * ($signed(40'(cfg.display_value_high)) - $signed(40'(cfg.display_value_low)));
    den = $signed({26'h0, cfg.span_high_hz}) - $signed({26'h0, cfg.span_low_hz});
    // A span of zero width cannot be divided, so it pins to the low display value
    lin = $signed(40'(cfg.display_value_low)) + ((den > 0) ? num / den : 40'sh0);
    case (cfg.unit)
      PER_MINUTE: mult = 40'(SEC_PER_MIN);
      PER_HOUR: mult = 40'(SEC_PER_HOUR);
      default: mult = 40'sh1;
    endcase
    ppl = (cfg.pulses_per_litre == 10'h0) ? 40'sh1 : $signed({30'h0, cfg.pulses_per_litre});
    // The point only changes how the digits read, never the digits themselves
    flow = (f * mult) / ppl;
    below = filt_rate < RATE_W'(cfg.span_low_hz);
    above = filt_rate > RATE_W'(cfg.span_high_hz);
    over = raw_rate > MAX_RATE_HZ;
    next_err_span = 1'b0;
    next_display = lin[31:0];
    if (cfg.mode == FLOW_MODE)
      next_display = flow[31:0];
    else
      case (cfg.limit)
        BOUND_WITH_ERROR: next_err_span = below || above;
        BOUND_WITH_CLAMP:
        begin
          if (below)
            next_display = 32'(cfg.display_value_low);
          else if (above)
            next_display = 32'(cfg.display_value_high);
        end
        default: next_display = lin[31:0];
      endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_display_value <= '0;
      o_err_over <= 1'b0;
      o_err_span <= 1'b0;
    end
    else if (scale_step)
    begin
      o_display_value <= next_display;
      o_err_over <= over;
      o_err_span <= next_err_span;
    end
  end
  // Only the point moves; digits keep the integer meaning of the value
  assign o_dp = cfg.dp;

  // AXI4-Lite write side: address and data taken in either order
  assign o_s_axi_awready = !aw_held && !o_s_axi_bvalid;
  assign o_s_axi_wready = !w_held && !o_s_axi_bvalid;
  assign do_write = aw_held && w_held && !o_s_axi_bvalid;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= (aw_addr <= REG_VALUE && aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (o_s_axi_bvalid && i_s_axi_bready)
        o_s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      ctrl_reg <= CTRL_RST;
      span_lo_reg <= SPAN_LO_RST;
      span_hi_reg <= SPAN_HI_RST;
      disp_lo_reg <= DISP_LO_RST;
      disp_hi_reg <= DISP_HI_RST;
      ppl_reg <= PPL_RST;
      smooth_reg <= SMOOTH_RST;
      mask <= STATUS_RST;
    end
    else if (do_write)
    begin
      if (aw_addr == REG_CTRL)
        ctrl_reg <= wmerge(ctrl_reg, w_data, w_strb);
      else if (aw_addr == REG_SPAN_LO)
        span_lo_reg <= wmerge(span_lo_reg, w_data, w_strb);
      else if (aw_addr == REG_SPAN_HI)
        span_hi_reg <= wmerge(span_hi_reg, w_data, w_strb);
      else if (aw_addr == REG_DISP_LO)
        disp_lo_reg <= wmerge(disp_lo_reg, w_data, w_strb);
      else if (aw_addr == REG_DISP_HI)
        disp_hi_reg <= wmerge(disp_hi_reg, w_data, w_strb);
      else if (aw_addr == REG_PPL)
        ppl_reg <= wmerge(ppl_reg, w_data, w_strb);
      else if (aw_addr == REG_SMOOTH)
        smooth_reg <= wmerge(smooth_reg, w_data, w_strb);
      else if (aw_addr == REG_MASK && w_strb[0])
        mask <= w_data[ST_W-1:0];
    end
  end

  // Sticky status; a new event wins over a write-one clear in the same cycle
  assign set_bits = {scale_step, scale_step && next_err_span, scale_step && over};
  assign clr_bits = (do_write && aw_addr == REG_STATUS && w_strb[0]) ? w_data[ST_W-1:0] : '0;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      status <= STATUS_RST;
    else
      status <= (status & ~clr_bits) | set_bits;
  end
  assign o_irq = |(status & mask);

  // AXI4-Lite read side: data one cycle after the address is taken
  assign o_s_axi_arready = !o_s_axi_rvalid;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= '0;
      o_s_axi_rresp <= RESP_OKAY;
    end
    else if (i_s_axi_arvalid && o_s_axi_arready)
    begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp <= RESP_OKAY;
      if (i_s_axi_araddr == REG_CTRL)
        o_s_axi_rdata <= ctrl_reg;
      else if (i_s_axi_araddr == REG_SPAN_LO)
        o_s_axi_rdata <= span_lo_reg;
      else if (i_s_axi_araddr == REG_SPAN_HI)
        o_s_axi_rdata <= span_hi_reg;
      else if (i_s_axi_araddr == REG_DISP_LO)
        o_s_axi_rdata <= disp_lo_reg;
      else if (i_s_axi_araddr == REG_DISP_HI)
        o_s_axi_rdata <= disp_hi_reg;
      else if (i_s_axi_araddr == REG_PPL)
        o_s_axi_rdata <= ppl_reg;
      else if (i_s_axi_araddr == REG_SMOOTH)
        o_s_axi_rdata <= smooth_reg;
      else if (i_s_axi_araddr == REG_STATUS)
        o_s_axi_rdata <= {29'h0, status};
      else if (i_s_axi_araddr == REG_MASK)
        o_s_axi_rdata <= {29'h0, mask};
      else if (i_s_axi_araddr == REG_RATE)
        o_s_axi_rdata <= {16'h0, raw_rate};
      else if (i_s_axi_araddr == REG_VALUE)
        o_s_axi_rdata <= o_display_value;
      else
      begin
        o_s_axi_rdata <= '0;
        o_s_axi_rresp <= RESP_SLVERR;
      end
    end
    else if (o_s_axi_rvalid && i_s_axi_rready)
      o_s_axi_rvalid <= 1'b0;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  a_npn_pullup: assert property (cfg.input_conditioning_select == NPN_CONTACT
      |-> o_pullup_en && !o_pulldown_en)
    else $error("NPN selection without pull-up only");
  a_span_low_map: assert property (scale_step && cfg.mode == PULSE_RATE_MODE
      && filt_rate == RATE_W'(cfg.span_low_hz) |=> o_display_value == 32'(cfg.display_value_low))
    else $error("Low span frequency did not show the low display value");
  a_limit_off_free: assert property (scale_step && cfg.mode == PULSE_RATE_MODE
      && cfg.limit == LIMIT_OFF |=> !o_err_span)
    else $error("Span error raised with range limit off");
  a_bound_error: assert property (scale_step && cfg.mode == PULSE_RATE_MODE
      && cfg.limit == BOUND_WITH_ERROR && (below || above) |=> o_err_span && status[ST_SPAN])
    else $error("Rate outside span did not raise the span error");
  a_clamp_low: assert property (scale_step && cfg.mode == PULSE_RATE_MODE
      && cfg.limit == BOUND_WITH_CLAMP && below |=> o_display_value == 32'(cfg.display_value_low))
    else $error("Clamp below span did not show the low display value");
  a_clamp_high: assert property (scale_step && cfg.mode == PULSE_RATE_MODE
      && cfg.limit == BOUND_WITH_CLAMP && !below && above
      |=> o_display_value == 32'(cfg.display_value_high))
    else $error("Clamp above span did not show the high display value");
  a_over_range: assert property (scale_step && raw_rate > MAX_RATE_HZ
      |=> o_err_over && status[ST_OVER])
    else $error("Rate above the absolute limit did not raise over-range");
  a_flow_zero: assert property (scale_step && cfg.mode == FLOW_MODE && filt_rate == '0
      |=> o_display_value == '0 && !o_err_span)
    else $error("Zero pulse rate gave a non-zero flow");
  a_status_sticky: assert property (status[ST_OVER] && !clr_bits[ST_OVER] |=> status[ST_OVER])
    else $error("Over-range status dropped without a clear");
  a_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready
      |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("Write response withdrawn before it was taken");

  c_clamp_event: cover property (scale_step && cfg.limit == BOUND_WITH_CLAMP && above);
  c_over_range: cover property (scale_step && over);
  c_flow_update: cover property (scale_step && cfg.mode == FLOW_MODE && filt_rate != '0);
  c_irq_rise: cover property ($rose(o_irq));

endmodule // pff_flow_meter

// ### tb/pff_pulse_src.sv
`timescale 1ns/1ns
module pff_pulse_src
  import pff_pkg::*;
(
  input wire logic i_core_clk,
  input wire pff_cond_type i_kind,
  input wire logic i_pullup_en,
  input wire logic i_pulldown_en,
  output logic o_line
);
  logic closed = 1'b0;
  // An open contact with no bias floats away from its idle level, never holding the last one
  always_comb
  begin
    case (i_kind)
      NPN_CONTACT: o_line = !closed && i_pullup_en;
      PNP_CONTACT: o_line = closed || !i_pulldown_en;
      default: o_line = ~closed;
    endcase
  end
  // One clean close and open per pulse; the input does no debouncing
  task automatic burst(input int k);
    repeat (k)
    begin
      @(posedge i_core_clk);
      closed <= 1'b1;
      @(posedge i_core_clk);
      closed <= 1'b0;
    end
  endtask
endmodule // pff_pulse_src

// ### tb/pff_flow_meter_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH at %0t got %h exp %h", $time, g, e); end end
module pff_flow_meter_tb;
  import pff_pkg::*;
  // Gate long enough to reach the over-range count, short enough for a brief run
  localparam int unsigned GATE = 20100;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pulse, pu, pd, e_over, e_span, irq, awrdy, wrdy, bvalid, arrdy, rvalid;
  pff_cond_type kind = LOGIC_LEVEL_INPUT;
  logic signed [31:0] disp;
  logic [1:0] dp, bresp, rresp, rs;
  logic [31:0] rdata, rd, st;
  logic [AXI_AW-1:0] awaddr = '0;
  logic [AXI_AW-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  int n_errors = 0;
  int check_count = 0;

  initial
  begin
    forever #5 clk = ~clk;
  end

  pff_flow_meter #(.GATE_CYCLES(GATE)) u_dut (
    .i_core_clk(clk), .i_rstn(rstn), .i_pulse(pulse), .o_pullup_en(pu), .o_pulldown_en(pd),
    .o_display_value(disp), .o_dp(dp), .o_err_over(e_over), .o_err_span(e_span), .o_irq(irq),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awrdy),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wrdy), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arrdy), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));

  pff_pulse_src u_src (.i_core_clk(clk), .i_kind(kind), .i_pullup_en(pu),
    .i_pulldown_en(pd), .o_line(pulse));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic hung;
    n_errors++;
    $display("MISMATCH at %0t got %h exp %h", $time, 1'b0, 1'b1);
    tally_and_finish();
  endtask

  task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d);
    logic awv = 1'b1;
    logic wv = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (50)
    begin
      @(posedge clk);
      awv = awv && !awrdy;
      wv = wv && !wrdy;
      awvalid <= awv;
      wvalid <= wv;
      if (bvalid)
      begin
        rs = bresp;
        bready <= 1'b0;
        return;
      end
    end
    hung();
  endtask

  task automatic rdr(input logic [AXI_AW-1:0] a);
    logic arv = 1'b1;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (50)
    begin
      @(posedge clk);
      arv = arv && !arrdy;
      arvalid <= arv;
      if (rvalid)
      begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        return;
      end
    end
    hung();
  endtask

  // Returns just after an update, so the next gate is counted from its start
  task automatic wait_upd(input logic [31:0] clr);
    int n = 0;
    while (irq !== 1'b1 && n < GATE + 100)
    begin
      @(posedge clk);
      n++;
    end
    if (irq !== 1'b1)
      hung();
    rdr(REG_STATUS);
    st = rd;
    wr(REG_STATUS, clr);
  endtask

  task automatic t_regs;
    rdr(REG_SPAN_HI);
    `CHK(rd, SPAN_HI_RST)
    rdr(REG_PPL);
    `CHK(rd, PPL_RST)
    rdr(REG_CTRL);
    `CHK(rd, CTRL_RST)
    rdr(8'h2c);
    `CHK(rs, RESP_SLVERR)
    wr(8'h05, 32'h1);
    `CHK(rs, RESP_SLVERR)
    wr(REG_MASK, 32'h4);
    rdr(REG_MASK);
    `CHK(rd, 32'h4)
    `CHK({pu, pd, dp, irq}, 5'h0)
    $display("test regs done");
  endtask

  task automatic t_linear;
    wr(REG_SPAN_LO, 32'h64);
    wr(REG_SPAN_HI, 32'h258);
    wr(REG_DISP_LO, 32'hfffffe0c);
    wr(REG_DISP_HI, 32'h1194);
    u_src.burst(700);
    wait_upd(32'h7);
    `CHK(disp, 32'sh157c)
    `CHK({e_over, e_span, pu, pd}, 4'h0)
    rdr(REG_RATE);
    `CHK(rd, 32'h2bc)
    $display("test linear done");
  endtask

  task automatic t_flow;
    wr(REG_CTRL, 32'ha3);
    wr(REG_PPL, 32'h8);
    kind <= NPN_CONTACT;
    u_src.burst(100);
    wait_upd(32'h7);
    `CHK(disp, 32'sh2ee)
    `CHK(dp, 2'h1)
    `CHK({pu, pd}, 2'h2)
    $display("test flow done");
  endtask

  task automatic t_error;
    wr(REG_CTRL, 32'hc);
    // One second of smoothing: half of the step from the last rate of 100 towards 50
    wr(REG_SMOOTH, 32'h64);
    kind <= PNP_CONTACT;
    u_src.burst(50);
    wait_upd(32'h7);
    `CHK(disp, 32'shfffffd12)
    `CHK(e_span, 1'b1)
    `CHK(st[ST_SPAN], 1'b1)
    `CHK(irq, 1'b0)
    `CHK({pu, pd}, 2'h1)
    $display("test error bound done");
  endtask

  task automatic t_clamp;
    wr(REG_CTRL, 32'h14);
    u_src.burst(10001);
    wait_upd(32'h4);
    `CHK(disp, 32'sh1194)
    `CHK(e_span, 1'b0)
    `CHK(e_over, 1'b1)
    rdr(REG_STATUS);
    `CHK(rd[ST_OVER], 1'b1)
    `CHK(irq, 1'b0)
    $display("test clamp done");
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    // The first gate runs from reset; the register test leaves it room for a whole burst
    t_regs();
    t_linear();
    t_flow();
    t_error();
    t_clamp();
    tally_and_finish();
  end
endmodule // pff_flow_meter_tb
